// ==== tq_pkg.sv ====
// Constants, register map and types of the trigger qualifier.
package tq_pkg;

  // Clock and time base; times are kept in picoseconds.
  localparam longint unsigned CLK_PERIOD_PS = 64'd25000;
  localparam longint unsigned B_DELAY_MIN_PS = 64'd20000;
  localparam longint unsigned B_DELAY_MAX_PS = 64'd6871946854000;
  localparam longint unsigned WIDTH_MIN_PS = 64'd20000;
  localparam longint unsigned WIDTH_MAX_PS = 64'd6871946854400;
  localparam longint unsigned LP5K_HOLD_PS = 64'd100000000;
  localparam longint unsigned LP100M_HOLD_PS = 64'd5000;
  localparam longint unsigned VSYNC_MIN_PS = 64'd10000000;
  localparam longint unsigned AUTO_PS = 64'd100000000000;

  // Least times round up, longest times round down, never below one.
  localparam int unsigned B_DELAY_MIN_CYC =
    32'((B_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned B_DELAY_MAX_CYC =
    32'(B_DELAY_MAX_PS / CLK_PERIOD_PS);
  localparam int unsigned WIDTH_MIN_CYC =
    32'((WIDTH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned WIDTH_MAX_CYC = 32'(WIDTH_MAX_PS / CLK_PERIOD_PS);
  localparam int unsigned LP5K_CYC =
    32'((LP5K_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned LP100M_CYC =
    32'((LP100M_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned VSYNC_MIN_CYC =
    32'((VSYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned AUTO_CYC = 32'(AUTO_PS / CLK_PERIOD_PS);

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_B_DELAY = 8'h04;
  localparam logic [7:0] REG_B_COUNT = 8'h08;
  localparam logic [7:0] REG_WIDTH_CFG = 8'h0C;
  localparam logic [7:0] REG_WIDTH_REF = 8'h10;
  localparam logic [7:0] REG_WIDTH_TOL = 8'h14;
  localparam logic [7:0] REG_VIDEO = 8'h18;
  localparam logic [7:0] REG_PAT_CARE = 8'h1C;
  localparam logic [7:0] REG_PAT_LEVEL = 8'h20;
  localparam logic [7:0] REG_PAT_CFG = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;

  // Control register fields.
  localparam int CTRL_ATYPE_LSB = 0;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_BEN_BIT = 3;
  localparam int CTRL_BEVT_BIT = 4;
  localparam int CTRL_BSLOPE_LSB = 5;
  localparam int CTRL_BSRC_LSB = 7;
  localparam int CTRL_ASRC_LSB = 12;
  localparam int CTRL_ASLOPE_LSB = 17;
  localparam int CTRL_LP5K_BIT = 19;
  localparam int CTRL_LP100M_BIT = 20;
  // Width, video, pattern and status fields.
  localparam int WCFG_NEG_BIT = 0;
  localparam int WCFG_MODE_LSB = 1;
  localparam int VID_STD_LSB = 0;
  localparam int VID_POSMOD_BIT = 3;
  localparam int VID_FIELD_LSB = 4;
  localparam int VID_LINE_LSB = 16;
  localparam int PCFG_OR_BIT = 0;
  localparam int PCFG_FALSE_BIT = 1;
  localparam int STAT_BBUSY_BIT = 0;
  localparam int STAT_AUTO_BIT = 1;
  localparam int STAT_PAT_BIT = 2;
  localparam int STAT_ODD_BIT = 3;
  localparam int STAT_LINE_LSB = 16;

  // Values after reset.
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam logic [31:0] B_COUNT_RST = 32'h0000_0001;
  localparam logic [31:0] WIDTH_CFG_RST = 32'h0000_0006;
  localparam logic [31:0] WIDTH_TOL_RST = 32'h0000_0000;
  localparam logic [31:0] VIDEO_RST = 32'h0001_0020;
  localparam logic [31:0] PAT_RST = 32'h0000_0000;

  typedef enum logic [1:0] {A_EDGE, A_WIDTH, A_VIDEO, A_PATTERN} tq_atype_t;
  typedef enum logic [1:0] {SL_RISE, SL_FALL, SL_EITHER} tq_slope_t;
  typedef enum logic [1:0] {
    WM_WITHIN, WM_OUTSIDE, WM_SHORTER, WM_LONGER
  } tq_wmode_t;
  typedef enum logic [2:0] {
    STD_PAL, STD_NTSC, STD_SECAM, STD_PALM,
    STD_576I, STD_720P, STD_1080P, STD_1080I
  } tq_std_t;
  typedef enum logic [2:0] {
    FLD_EVEN, FLD_ODD, FLD_ALL, FLD_LINE, FLD_EVERY_LINE
  } tq_field_t;
  typedef enum logic [1:0] {BS_IDLE, BS_DELAY, BS_WAIT} tq_bstate_t;

  // Highest line number of each video standard.
  function automatic logic [11:0] tq_line_max(input logic [2:0] std);
    logic [11:0] m;
    m = 12'h271;
    if (std == 3'h1 || std == 3'h3) m = 12'h20D;
    if (std == 3'h5) m = 12'h2EE;
    if (std == 3'h6 || std == 3'h7) m = 12'h465;
    return m;
  endfunction

endpackage

// ==== tq_trigger_qualifier.sv ====
// Trigger qualifier: edge, width, video and pattern A stage plus B stage.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module tq_trigger_qualifier #(
  parameter int unsigned B_DELAY_MAX_CYC = tq_pkg::B_DELAY_MAX_CYC,
  parameter int unsigned WIDTH_MAX_CYC = tq_pkg::WIDTH_MAX_CYC,
  parameter int unsigned AUTO_CYC = tq_pkg::AUTO_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic analog_input_one,
  input wire logic analog_input_two,
  input wire logic analog_input_three,
  input wire logic analog_input_four,
  input wire logic [15:0] logic_inputs,
  input wire logic four_channels,
  input wire logic logic_fitted,
  output logic trig_out,
  output logic trig_auto
);

  logic [31:0] ctrl_reg, b_delay_reg, b_count_reg, wcfg_reg;
  logic [31:0] wref_reg, wtol_reg, video_reg, care_reg, level_reg, pcfg_reg;
  logic [21:0] sync1_reg, sync2_reg;
  logic [19:0] src_vec, present, bit_ok;
  logic [4:0] asrc_sel, bsrc_sel;
  logic a_lvl, b_lvl, b_prev_reg, a_filt_reg, a_filt, a_prev_reg;
  logic [11:0] lp_cnt_reg, lp_need;
  tq_pkg::tq_atype_t a_type;
  tq_pkg::tq_slope_t a_slope, b_slope;
  tq_pkg::tq_wmode_t wmode;
  tq_pkg::tq_field_t fmode;
  tq_pkg::tq_bstate_t bstate_reg, bstate_next;
  logic [2:0] std;
  logic [11:0] line_max;
  logic a_rise, a_fall, b_rise, b_fall, edge_hit, b_hit;

  // Input pins cross from the front end; two flops before any use.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 22'h00_0000;
      sync2_reg <= 22'h00_0000;
    end else begin
      sync1_reg <= {logic_fitted, four_channels, logic_inputs,
                    analog_input_four, analog_input_three,
                    analog_input_two, analog_input_one};
      sync2_reg <= sync1_reg;
    end
  end

  // Field decode of the control and setup registers.
  assign a_type = tq_pkg::tq_atype_t'(ctrl_reg[tq_pkg::CTRL_ATYPE_LSB +: 2]);
  assign a_slope = tq_pkg::tq_slope_t'(ctrl_reg[tq_pkg::CTRL_ASLOPE_LSB +: 2]);
  assign b_slope = tq_pkg::tq_slope_t'(ctrl_reg[tq_pkg::CTRL_BSLOPE_LSB +: 2]);
  assign asrc_sel = ctrl_reg[tq_pkg::CTRL_ASRC_LSB +: 5];
  assign bsrc_sel = ctrl_reg[tq_pkg::CTRL_BSRC_LSB +: 5];
  assign wmode = tq_pkg::tq_wmode_t'(wcfg_reg[tq_pkg::WCFG_MODE_LSB +: 2]);
  assign fmode = tq_pkg::tq_field_t'(video_reg[tq_pkg::VID_FIELD_LSB +: 3]);
  assign std = video_reg[tq_pkg::VID_STD_LSB +: 3];
  assign line_max = tq_pkg::tq_line_max(std);

  // Source vector: analog first, then digital 0..15; absent ones read low.
  assign present = {{16{sync2_reg[21]}}, {2{sync2_reg[20]}}, 2'b11};
  assign src_vec = sync2_reg[19:0] & present;
  assign a_lvl = (asrc_sel < 5'h14) ? src_vec[asrc_sel] : 1'b0;
  assign b_lvl = (bsrc_sel < 5'h14) ? src_vec[bsrc_sel] : 1'b0;

  // Lowpass filters: a level must hold for the filter time to pass.
  // A hold filter is cheaper than a true IIR and rejects the same glitches.
  assign lp_need = ctrl_reg[tq_pkg::CTRL_LP5K_BIT] ?
                   12'(tq_pkg::LP5K_CYC) :
                   (ctrl_reg[tq_pkg::CTRL_LP100M_BIT] ?
                    12'(tq_pkg::LP100M_CYC) : 12'h000);
  assign a_filt = (lp_need == 12'h000) ? a_lvl : a_filt_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lp_cnt_reg <= 12'h000;
      a_filt_reg <= 1'b0;
    end else if (a_lvl == a_filt_reg) begin
      lp_cnt_reg <= 12'h000;
    end else if (lp_cnt_reg + 12'h001 >= lp_need) begin
      lp_cnt_reg <= 12'h000;
      a_filt_reg <= a_lvl;
    end else begin
      lp_cnt_reg <= lp_cnt_reg + 12'h001;
    end
  end

  // Edge detection of the A and B sources.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
    end else begin
      a_prev_reg <= a_filt;
      b_prev_reg <= b_lvl;
    end
  end
  assign a_rise = a_filt & ~a_prev_reg;
  assign a_fall = ~a_filt & a_prev_reg;
  assign b_rise = b_lvl & ~b_prev_reg;
  assign b_fall = ~b_lvl & b_prev_reg;
  assign edge_hit = (a_slope == tq_pkg::SL_RISE) ? a_rise :
                    (a_slope == tq_pkg::SL_FALL) ? a_fall : (a_rise | a_fall);
  assign b_hit = (b_slope == tq_pkg::SL_RISE) ? b_rise :
                 (b_slope == tq_pkg::SL_FALL) ? b_fall :
                 (b_rise | b_fall);

  // Width measurement in clock cycles.
  logic w_start, w_end, w_act_reg, w_hit;
  logic [31:0] w_cnt_reg;
  logic [32:0] w_hi, w_lo;
  logic w_within;
  assign w_start = wcfg_reg[tq_pkg::WCFG_NEG_BIT] ? a_fall : a_rise;
  assign w_end = wcfg_reg[tq_pkg::WCFG_NEG_BIT] ? a_rise : a_fall;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_act_reg <= 1'b0;
      w_cnt_reg <= 32'h0000_0000;
    end else if (w_start) begin
      w_act_reg <= 1'b1;
      w_cnt_reg <= 32'h0000_0001;
    end else begin
      if (w_end) w_act_reg <= 1'b0;
      if (w_act_reg && w_cnt_reg != 32'hFFFF_FFFF) begin
        w_cnt_reg <= w_cnt_reg + 32'h0000_0001;
      end
    end
  end
  // Lower bound saturates at zero in case the reference shrank later.
  assign w_hi = {1'b0, wref_reg} + {1'b0, wtol_reg};
  assign w_lo = (wtol_reg > wref_reg) ? 33'h0_0000_0000 :
                {1'b0, wref_reg - wtol_reg};
  assign w_within = ({1'b0, w_cnt_reg} >= w_lo) &&
                    ({1'b0, w_cnt_reg} <= w_hi);
  assign w_hit = w_end & w_act_reg &
                 ((wmode == tq_pkg::WM_WITHIN) ? w_within :
                  (wmode == tq_pkg::WM_OUTSIDE) ? ~w_within :
                  (wmode == tq_pkg::WM_SHORTER) ? (w_cnt_reg < wref_reg) :
                  (w_cnt_reg > wref_reg));

  // Video sync: sync pulses have the polarity opposite the modulation.
  logic sync_act, sync_prev_reg, sync_end, broad, interlaced, new_odd;
  logic in_vblank_reg, odd_reg, field_start, line_evt, v_hit;
  logic [15:0] sync_cnt_reg;
  logic [11:0] line_reg;
  assign sync_act = video_reg[tq_pkg::VID_POSMOD_BIT] ? ~a_lvl : a_lvl;
  assign sync_end = ~sync_act & sync_prev_reg;
  assign broad = sync_end && (sync_cnt_reg >= 16'(tq_pkg::VSYNC_MIN_CYC));
  assign field_start = broad & ~in_vblank_reg;
  assign line_evt = sync_end & ~broad;
  assign interlaced = (std != 3'h5) && (std != 3'h6);
  assign new_odd = interlaced ? ~odd_reg : 1'b1;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_prev_reg <= 1'b0;
      sync_cnt_reg <= 16'h0000;
      in_vblank_reg <= 1'b0;
      odd_reg <= 1'b0;
      line_reg <= 12'h000;
    end else begin
      sync_prev_reg <= sync_act;
      if (!sync_act) sync_cnt_reg <= 16'h0000;
      else if (sync_cnt_reg != 16'hFFFF) sync_cnt_reg <= sync_cnt_reg + 16'h0001;
      if (broad) in_vblank_reg <= 1'b1;
      else if (line_evt) in_vblank_reg <= 1'b0;
      if (field_start) odd_reg <= new_odd;
      if (field_start && new_odd) line_reg <= 12'h000;
      else if (line_evt && line_reg < line_max) line_reg <= line_reg + 12'h001;
    end
  end
  always_comb begin
    unique case (fmode)
      tq_pkg::FLD_EVEN: v_hit = field_start & interlaced & ~new_odd;
      tq_pkg::FLD_ODD: v_hit = field_start & interlaced & new_odd;
      tq_pkg::FLD_ALL: v_hit = field_start;
      tq_pkg::FLD_LINE: v_hit = line_evt &&
        (line_reg + 12'h001 == video_reg[tq_pkg::VID_LINE_LSB +: 12]);
      tq_pkg::FLD_EVERY_LINE: v_hit = line_evt;
      default: v_hit = 1'b0;
    endcase
  end

  // Pattern match, one comparator per position.
  logic all_ok, any_ok, pat_cond, pat_prev_reg, p_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 20; gi++) begin : g_pat
      assign bit_ok[gi] = (src_vec[gi] == level_reg[gi]);
    end
  endgenerate
  assign all_ok = &(~(care_reg[19:0] & present) | bit_ok);
  assign any_ok = |(care_reg[19:0] & present & bit_ok);
  assign pat_cond = (pcfg_reg[tq_pkg::PCFG_OR_BIT] ? any_ok : all_ok) ^
                    pcfg_reg[tq_pkg::PCFG_FALSE_BIT];
  assign p_hit = pat_cond & ~pat_prev_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) pat_prev_reg <= 1'b0;
    else pat_prev_reg <= pat_cond;
  end

  // A stage trigger selection.
  logic a_hit;
  assign a_hit = (a_type == tq_pkg::A_EDGE) ? edge_hit :
                 (a_type == tq_pkg::A_WIDTH) ? w_hit :
                 (a_type == tq_pkg::A_VIDEO) ? v_hit : p_hit;

  // B stage: delay after each A trigger unless in event mode, then qualify B edges.
  logic [31:0] b_cnt_reg, b_cnt_next;
  logic b_en, b_evt_mode, real_fire;
  assign b_en = ctrl_reg[tq_pkg::CTRL_BEN_BIT];
  assign b_evt_mode = ctrl_reg[tq_pkg::CTRL_BEVT_BIT];
  always_comb begin
    bstate_next = bstate_reg;
    b_cnt_next = b_cnt_reg;
    real_fire = 1'b0;
    if (!b_en) begin
      bstate_next = tq_pkg::BS_IDLE;
      real_fire = a_hit;
    end else if (a_hit) begin
      // A fresh A trigger restarts the delay or the event count.
      bstate_next = b_evt_mode ? tq_pkg::BS_WAIT : tq_pkg::BS_DELAY;
      b_cnt_next = 32'h0000_0000;
    end else begin
      unique case (bstate_reg)
        tq_pkg::BS_IDLE: b_cnt_next = 32'h0000_0000;
        tq_pkg::BS_DELAY: begin
          b_cnt_next = b_cnt_reg + 32'h0000_0001;
          if (b_cnt_next >= b_delay_reg) bstate_next = tq_pkg::BS_WAIT;
        end
        tq_pkg::BS_WAIT: begin
          if (b_hit) begin
            b_cnt_next = b_cnt_reg + 32'h0000_0001;
            if (!b_evt_mode || b_cnt_next >= b_count_reg) begin
              real_fire = 1'b1;
              bstate_next = tq_pkg::BS_IDLE;
            end
          end
        end
        default: bstate_next = tq_pkg::BS_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bstate_reg <= tq_pkg::BS_IDLE;
      b_cnt_reg <= 32'h0000_0000;
    end else begin
      bstate_reg <= bstate_next;
      b_cnt_reg <= b_cnt_next;
    end
  end

  // Trigger mode: auto self-triggers after an idle interval.
  logic [31:0] auto_cnt_reg;
  logic auto_fire, auto_last_reg;
  assign auto_fire = ctrl_reg[tq_pkg::CTRL_AUTO_BIT] && !real_fire &&
                     (auto_cnt_reg >= AUTO_CYC - 1);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      auto_cnt_reg <= 32'h0000_0000;
      trig_out <= 1'b0;
      trig_auto <= 1'b0;
      auto_last_reg <= 1'b0;
    end else begin
      trig_out <= real_fire | auto_fire;
      trig_auto <= auto_fire;
      if (real_fire | auto_fire) begin
        auto_cnt_reg <= 32'h0000_0000;
        auto_last_reg <= auto_fire;
      end else begin
        auto_cnt_reg <= auto_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Delay, width, tolerance and line number writes are clamped into their legal ranges.
  logic [31:0] dly_w, ref_w, tol_w, cnt_w, vid_w;
  logic [11:0] line_w;
  assign dly_w = (reg_wdata < tq_pkg::B_DELAY_MIN_CYC) ?
                 tq_pkg::B_DELAY_MIN_CYC :
                 (reg_wdata > B_DELAY_MAX_CYC) ? B_DELAY_MAX_CYC :
                 reg_wdata;
  assign ref_w = (reg_wdata < tq_pkg::WIDTH_MIN_CYC) ?
                 tq_pkg::WIDTH_MIN_CYC :
                 (reg_wdata > WIDTH_MAX_CYC) ? WIDTH_MAX_CYC : reg_wdata;
  assign tol_w = (reg_wdata > wref_reg) ? wref_reg : reg_wdata;
  assign cnt_w = (reg_wdata[15:0] == 16'h0000) ? 32'h0000_0001 :
                 {16'h0000, reg_wdata[15:0]};
  assign line_w = (reg_wdata[27:16] == 12'h000) ? 12'h001 :
    (reg_wdata[27:16] > tq_pkg::tq_line_max(reg_wdata[2:0])) ?
    tq_pkg::tq_line_max(reg_wdata[2:0]) : reg_wdata[27:16];
  assign vid_w = {4'h0, line_w, 9'h000, reg_wdata[6:0]};

  // Register writes; a single strobe per cycle selects one register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= tq_pkg::CTRL_RST;
      b_delay_reg <= tq_pkg::B_DELAY_MIN_CYC;
      b_count_reg <= tq_pkg::B_COUNT_RST;
      wcfg_reg <= tq_pkg::WIDTH_CFG_RST;
      wref_reg <= tq_pkg::WIDTH_MIN_CYC;
      wtol_reg <= tq_pkg::WIDTH_TOL_RST;
      video_reg <= tq_pkg::VIDEO_RST;
      care_reg <= tq_pkg::PAT_RST;
      level_reg <= tq_pkg::PAT_RST;
      pcfg_reg <= tq_pkg::PAT_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        tq_pkg::REG_CTRL: ctrl_reg <= {11'h000, reg_wdata[20:0]};
        tq_pkg::REG_B_DELAY: b_delay_reg <= dly_w;
        tq_pkg::REG_B_COUNT: b_count_reg <= cnt_w;
        tq_pkg::REG_WIDTH_CFG: wcfg_reg <= {29'h0000_0000, reg_wdata[2:0]};
        tq_pkg::REG_WIDTH_REF: wref_reg <= ref_w;
        tq_pkg::REG_WIDTH_TOL: wtol_reg <= tol_w;
        tq_pkg::REG_VIDEO: video_reg <= vid_w;
        tq_pkg::REG_PAT_CARE: care_reg <= {12'h000, reg_wdata[19:0]};
        tq_pkg::REG_PAT_LEVEL: level_reg <= {12'h000, reg_wdata[19:0]};
        tq_pkg::REG_PAT_CFG: pcfg_reg <= {30'h0000_0000, reg_wdata[1:0]};
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero.
  logic [31:0] status_w, rd_mux;
  assign status_w = {4'h0, line_reg, 12'h000, odd_reg, pat_cond,
                     auto_last_reg, (bstate_reg != tq_pkg::BS_IDLE)};
  assign rd_mux = (reg_addr == tq_pkg::REG_CTRL) ? ctrl_reg :
                  (reg_addr == tq_pkg::REG_B_DELAY) ? b_delay_reg :
                  (reg_addr == tq_pkg::REG_B_COUNT) ? b_count_reg :
                  (reg_addr == tq_pkg::REG_WIDTH_CFG) ? wcfg_reg :
                  (reg_addr == tq_pkg::REG_WIDTH_REF) ? wref_reg :
                  (reg_addr == tq_pkg::REG_WIDTH_TOL) ? wtol_reg :
                  (reg_addr == tq_pkg::REG_VIDEO) ? video_reg :
                  (reg_addr == tq_pkg::REG_PAT_CARE) ? care_reg :
                  (reg_addr == tq_pkg::REG_PAT_LEVEL) ? level_reg :
                  (reg_addr == tq_pkg::REG_PAT_CFG) ? pcfg_reg :
                  (reg_addr == tq_pkg::REG_STATUS) ? status_w :
                  32'h0000_0000;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) reg_rdata <= 32'h0000_0000;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 32'h0000_0000;
  end

endmodule

// ==== tq_trigger_qualifier_asserts.sv ====
// Port checker for the trigger qualifier, bound to its top module.
`timescale 1ns/1ps
module tq_checker #(
  parameter int unsigned B_DELAY_MAX_CYC = 1000,
  parameter int unsigned WIDTH_MAX_CYC = 1000,
  parameter int unsigned AUTO_CYC = 50
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic analog_input_one,
  input wire logic trig_out,
  input wire logic trig_auto
);
  logic [20:0] ctrl_reg;
  logic [19:0] care_reg;
  // Shadows of what software wrote, so reads can be judged.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= 21'h00_0004;
      care_reg <= 20'h0_0000;
    end else if (reg_wr && reg_addr == 8'h00) begin
      ctrl_reg <= reg_wdata[20:0];
    end else if (reg_wr && reg_addr == 8'h1C) begin
      care_reg <= reg_wdata[19:0];
    end
  end
  // Edge type on the first channel, rising, no filter, B and auto off.
  wire plain_edge = ctrl_reg == 21'h00_0000;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  auto_flag_a: assert property (trig_auto |-> trig_out)
    else $error("auto flag without trigger");
  auto_off_a: assert property (!ctrl_reg[2] && !$past(ctrl_reg[2]) |-> !trig_auto)
    else $error("auto trigger in normal mode");
  edge_delay_a: assert property (plain_edge && $rose(analog_input_one) |-> ##3 trig_out ##1 !trig_out)
    else $error("edge trigger late or long");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  rd_hole_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'hFC |-> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  care_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1C |-> reg_rdata == {12'h000, $past(care_reg)})
    else $error("pattern care read wrong");
  ctrl_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00 |-> reg_rdata == {11'h000, $past(ctrl_reg)})
    else $error("control read wrong");
  rst_quiet_a: assert property ($rose(nrst) |-> !trig_out && !trig_auto)
    else $error("trigger right after reset");
  cover property (trig_auto);
  cover property (plain_edge && trig_out);
  cover property ($past(reg_rd) && $past(reg_addr) == 8'h1C);
endmodule
bind tq_trigger_qualifier tq_checker #(.B_DELAY_MAX_CYC(B_DELAY_MAX_CYC),
  .WIDTH_MAX_CYC(WIDTH_MAX_CYC), .AUTO_CYC(AUTO_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .analog_input_one(analog_input_one), .trig_out(trig_out),
  .trig_auto(trig_auto));

// ==== tq_chan_model.sv ====
// Thresholded front-end channels: four analog, then sixteen logic inputs.
`timescale 1ns/1ps
module tq_chan_model (
  input wire logic clk,
  input wire logic [19:0] level,
  output logic [19:0] state
);
  // Comparators settle one sample after the level is set.
  always @(posedge clk) begin
    state <= level;
  end
endmodule

// ==== test_trigger_qualifier.sv ====
// Self-checking bench for the trigger qualifier.
`timescale 1ns/1ps
module test_trigger_qualifier;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic fitted = 1'b1;
  logic [19:0] lv = 20'h0_0000;
  wire [31:0] reg_rdata;
  wire [19:0] ch;
  wire trig_out;
  wire trig_auto;
  int n_errors = 0;
  int checked = 0;
  int hits;
  logic [11:0] lmax [8] = '{12'h271, 12'h20D, 12'h271, 12'h20D, 12'h271,
    12'h2EE, 12'h465, 12'h465};
  logic [1:0] wm [8] = '{2'h3, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1};
  int wd [8] = '{5, 15, 5, 15, 10, 11, 10, 11};
  int we [8] = '{0, 1, 1, 0, 1, 0, 0, 1};
  tq_chan_model u_chan (.clk(clk), .level(lv), .state(ch));
  tq_trigger_qualifier #(.B_DELAY_MAX_CYC(1000), .WIDTH_MAX_CYC(1000),
    .AUTO_CYC(50)) u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .analog_input_one(ch[0]),
    .analog_input_two(ch[1]), .analog_input_three(ch[2]),
    .analog_input_four(ch[3]), .logic_inputs(ch[19:4]),
    .four_channels(fitted), .logic_fitted(fitted), .trig_out(trig_out),
    .trig_auto(trig_auto));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Writes leave a few idle cycles so a config change settles first.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
    @(posedge clk);
  endtask
  // Counts trigger pulses, sampled mid-cycle where they are settled.
  task automatic run(input int n);
    repeat (n) begin
      @(negedge clk);
      if (trig_out === 1'b1) hits++;
      @(posedge clk);
    end
  endtask
  task automatic lv_hits(input logic [19:0] v, input int n, input int e);
    hits = 0;
    lv <= v;
    run(n);
    check(32'(hits), 32'(e));
  endtask
  task automatic complete_run();
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(8'h00, tq_pkg::CTRL_RST);
    rd(8'h04, 32'h0000_0001);
    rd(8'h08, tq_pkg::B_COUNT_RST);
    rd(8'h0C, tq_pkg::WIDTH_CFG_RST);
    rd(8'h10, 32'h0000_0001);
    rd(8'h18, tq_pkg::VIDEO_RST);
    rd(8'h24, tq_pkg::PAT_RST);
    rd(8'hFC, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    rd(8'h08, 32'h0000_0001);
    wr(8'h10, 32'h0000_0003);
    wr(8'h14, 32'h0000_0009);
    rd(8'h14, 32'h0000_0003);
    for (int s = 0; s < 8; s++) begin
      wr(8'h18, 32'h0FFF_0020 | 32'(s));
      rd(8'h18, {4'h0, lmax[s], 16'h0020} | 32'(s));
    end
    wr(8'h00, 32'h0000_0004);
    hits = 0;
    run(130);
    check(32'(hits >= 2), 32'h0000_0001);
    rd(8'h28, 32'h0000_0006);
    wr(8'h00, 32'h0000_0000);
    lv_hits(20'h0_0001, 12, 1);
    lv_hits(20'h0_0000, 12, 0);
    wr(8'h00, 32'h0002_0000);
    lv_hits(20'h0_0001, 12, 0);
    lv_hits(20'h0_0000, 12, 1);
    wr(8'h00, 32'h0010_0000);
    lv_hits(20'h0_0001, 12, 1);
    wr(8'h00, 32'h0008_0000);
    lv_hits(20'h0_0000, 4020, 0);
    lv_hits(20'h0_0001, 4020, 1);
    lv_hits(20'h0_0000, 12, 0);
    wr(8'h08, 32'h0000_0003);
    wr(8'h00, 32'h0000_0098);
    lv_hits(20'h0_0001, 12, 0);
    for (int i = 1; i <= 3; i++) begin
      lv_hits(20'h0_0003, 12, (i == 3) ? 1 : 0);
      lv_hits(20'h0_0001, 12, 0);
    end
    lv_hits(20'h0_0000, 12, 0);
    wr(8'h04, 32'h0000_0028);
    wr(8'h00, 32'h0000_0088);
    lv_hits(20'h0_0001, 12, 0);
    lv_hits(20'h0_0003, 12, 0);
    lv_hits(20'h0_0001, 30, 0);
    lv_hits(20'h0_0003, 12, 1);
    lv_hits(20'h0_0000, 12, 0);
    wr(8'h10, 32'h0000_000A);
    wr(8'h14, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      wr(8'h0C, {29'h0, wm[i], 1'b0});
      hits = 0;
      lv <= 20'h0_0001;
      run(wd[i]);
      lv <= 20'h0_0000;
      run(20);
      check(32'(hits), 32'(we[i]));
    end
    wr(8'h0C, 32'h0000_0007);
    lv_hits(20'h0_0001, 12, 0);
    lv_hits(20'h0_0000, 15, 0);
    lv_hits(20'h0_0001, 12, 1);
    lv_hits(20'h0_0000, 12, 0);
    wr(8'h1C, 32'h0000_0003);
    rd(8'h1C, 32'h0000_0003);
    wr(8'h20, 32'h0000_0001);
    wr(8'h00, 32'h0000_0003);
    lv_hits(20'h0_0001, 12, 1);
    lv_hits(20'h0_0003, 12, 0);
    wr(8'h24, 32'h0000_0002);
    lv_hits(20'h0_0001, 12, 0);
    lv_hits(20'h0_0003, 12, 1);
    wr(8'h24, 32'h0000_0001);
    lv_hits(20'h0_0002, 12, 0);
    lv_hits(20'h0_0000, 12, 1);
    wr(8'h18, 32'h0001_0040);
    wr(8'h00, 32'h0000_0002);
    lv_hits(20'h0_0001, 12, 0);
    lv_hits(20'h0_0000, 12, 1);
    wr(8'h18, 32'h0001_0048);
    lv_hits(20'h0_0001, 12, 1);
    lv_hits(20'h0_0000, 12, 0);
    wr(8'h00, 32'h0000_4000);
    lv_hits(20'h0_0010, 12, 1);
    wr(8'h00, 32'h0000_2000);
    lv_hits(20'h0_0004, 12, 1);
    lv_hits(20'h0_0000, 12, 0);
    fitted <= 1'b0;
    lv_hits(20'h0_0004, 12, 0);
    wr(8'h00, 32'h0000_4000);
    lv_hits(20'h0_0010, 12, 0);
    complete_run();
  end
endmodule
